// File: shared/adc_trig_cfg.svh
// constants of the hardware-triggered converter sequencer
// Overview of operation
// - timer-source trigger starts on its rising edge
// - timer trigger ORs four selectable timer events
// - each converter owns its trigger pair
// - enable arms converter; trigger starts conversion
// - result store and interrupt together
// - after sequence, wait for trigger again
// - active flag one while converting
// - trigger during conversion restarts it
// - mode/trigger/channel write stops, returns waiting
// - closely spaced triggers: latest one wins
// - 1-buffer: one conversion, own-channel register, interrupt
// - 4-buffer: four results, interrupt after fourth
// - scan: channels 0..selected, interrupt at end
// - external edge: rising, falling or both
// - disabling mid-conversion stores nothing
// - enable stays set after interrupt
`ifndef ADC_TRIG_CFG_SVH
`define ADC_TRIG_CFG_SVH

// register offsets
`define CONV_BLOCK_BIT   6
`define OFF_MODE         6'h00
`define OFF_CLK          6'h04
`define OFF_TRIG         6'h08
`define OFF_CHAN         6'h0c
`define OFF_RES0         6'h10
`define OFF_RES3         6'h1c
`define OFF_TOPT_A       8'h80
`define OFF_TOPT_B       8'h84
`define OFF_IRQ_STS      8'h88
`define OFF_IRQ_MSK      8'h8c

// field positions
`define MODE_EN_BIT      7
`define MODE_ACT_BIT     6
`define MODE_OPM_LSB     4
`define MODE_ETS_LSB     2
`define TRIG_SRC_BIT     1
`define TRIG_BUF4_BIT    0

// reset values
`define MODE_RST         8'h00
`define CLK_RST          2'h1
`define TRIG_RST         2'h0
`define CHAN_RST         2'h0
`define TOPT_RST         4'h0
`define IRQ_RST          2'h0

// conversion length in sys_clk cycles per clock-count setting
`define CONV_CYC_SET1    8'd62
`define CONV_CYC_SET2    8'd93
`define CONV_CYC_SET3    8'd124

`endif

// File: shared/adc_trig_pkg.sv
// types of the hardware-triggered converter sequencer
`default_nettype none
package adc_trig_pkg;
  // one-hot sequencer state
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_e;

  // valid edge of the external trigger pin
  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } edge_sel_e;
endpackage : adc_trig_pkg
`default_nettype wire

// File: rtl/conv_sequencer.sv
// per-converter conversion sequencer: select 1/4-buffer and scan
`default_nettype none
module conv_sequencer #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             enable,
  input  wire logic             start,
  input  wire logic             stop_req,
  input  wire logic             buf4,
  input  wire logic             scan,
  input  wire logic [1:0]       chan_sel,
  input  wire logic [7:0]       conv_cycles,
  // converter data
  input  wire logic [RES_W-1:0] sample_data,
  // results and status
  output logic                  active,
  output logic                  store_we,
  output logic [1:0]            store_idx,
  output logic [RES_W-1:0]      store_data,
  output logic                  done,
  output logic [1:0]            chan
);
  import adc_trig_pkg::*;

  seq_state_e state_r;
  seq_state_e state_nxt;
  logic [7:0] cnt_r;
  logic [1:0] step_r;

  // sequencing decode
  wire        converting = (state_r == SEQ_CONV);
  wire [7:0]  last_cnt   = conv_cycles - 8'd1;
  wire        conv_end   = converting && (cnt_r == last_cnt);
  wire        last_step  = scan ? (step_r == chan_sel) :
                           buf4 ? (step_r == 2'd3) : 1'b1;
  wire [1:0]  cur_idx    = (scan || buf4) ? step_r : chan_sel;
  wire        do_store   = enable && !stop_req && !start && conv_end;
  wire        do_done    = do_store && last_step;

  assign active = converting;

  // next state: disable, register write, trigger, end of sequence
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SEQ_IDLE:
      begin
        if (enable && !stop_req && start)
          state_nxt = SEQ_CONV;
      end
      SEQ_CONV:
      begin
        if (!enable)
          state_nxt = SEQ_IDLE;
        else if (stop_req)
          state_nxt = SEQ_IDLE;
        else if (start)
          state_nxt = SEQ_CONV;
        else if (do_done)
          state_nxt = SEQ_IDLE;
      end
      default:
        state_nxt = SEQ_IDLE;
    endcase
  end

  // state, cycle and step counters
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= SEQ_IDLE;
      cnt_r   <= 8'h00;
      step_r  <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (start || state_nxt != SEQ_CONV || do_store)
        cnt_r <= 8'h00;
      else
        cnt_r <= cnt_r + 8'd1;
      if (start || state_nxt != SEQ_CONV)
        step_r <= 2'h0;
      else if (do_store)
        step_r <= step_r + 2'd1;
    end
  end

  // result strobe, conversion end pulse and analog channel
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      store_we   <= 1'b0;
      store_idx  <= 2'h0;
      store_data <= '0;
      done       <= 1'b0;
      chan       <= 2'h0;
    end
    else
    begin
      store_we   <= do_store;
      store_idx  <= cur_idx;
      store_data <= sample_data;
      done       <= do_done;
      chan       <= scan ? step_r : chan_sel;
    end
  end
endmodule : conv_sequencer
`default_nettype wire

// File: rtl/adc_trig_top.sv
// two-converter hardware trigger sequencer with apb register file
//
// Local design decisions: the register addresses and the APB register port.
`include "adc_trig_cfg.svh"
`default_nettype none
module adc_trig_top #(
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // apb slave
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // motor-control timer events
  input  wire logic             timer_p_compare0_event,
  input  wire logic             timer_p_compare1_event,
  input  wire logic             timer_q_compare0_event,
  input  wire logic             timer_q_overflow_event,
  // external trigger pins
  input  wire logic             ext_trigger_pin0,
  input  wire logic             ext_trigger_pin1,
  // converter sample data
  input  wire logic [RES_W-1:0] sample_data0,
  input  wire logic [RES_W-1:0] sample_data1,
  // analog channel being converted
  output logic [1:0]            analog_input_channel0,
  output logic [1:0]            analog_input_channel1,
  // interrupt
  output logic                  conversion_end_irq
);
  import adc_trig_pkg::*;

  // software registers
  logic [7:0]       conv_mode_reg_r         [2];
  logic [1:0]       conv_clock_reg_r        [2];
  logic [1:0]       conv_trigger_mode_reg_r [2];
  logic [1:0]       channel_select_reg_r    [2];
  logic [RES_W-1:0] result_reg_r            [8];
  logic [3:0]       timer_option_reg_a_r;
  logic [3:0]       timer_option_reg_b_r;
  logic [1:0]       irq_sts_r;
  logic [1:0]       irq_msk_r;
  logic [1:0]       irq_sts_nxt;

  // trigger conditioning
  logic [1:0]       ext_meta_r;
  logic [1:0]       ext_sync_r;
  logic [1:0]       ext_prev_r;
  logic [1:0]       tmr_prev_r;
  logic [1:0]       start_r;

  // sequencer links
  logic [1:0]       seq_active;
  logic [1:0]       seq_store_we;
  logic [1:0]       seq_store_idx [2];
  logic [RES_W-1:0] seq_store_data [2];
  logic [1:0]       seq_done;
  logic [1:0]       stop_req_r;
  logic [1:0]       seq_chan [2];

  // timer trigger: or of the selected events
  function automatic logic timer_trig(input logic [3:0] sel, input logic [3:0] ev);
    timer_trig = |(sel & ev);
  endfunction : timer_trig

  // external edge qualification
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prv);
    edge_hit = ((sel == EDGE_RISING || sel == EDGE_BOTH) && cur && !prv) ||
               ((sel == EDGE_FALLING || sel == EDGE_BOTH) && !cur && prv);
  endfunction : edge_hit

  // conversion length from the clock-count field
  function automatic logic [7:0] conv_len(input logic [1:0] fr);
    conv_len = (fr == 2'd3) ? `CONV_CYC_SET3 :
               (fr == 2'd2) ? `CONV_CYC_SET2 : `CONV_CYC_SET1;
  endfunction : conv_len

  // apb decode
  wire        xfer_wr   = psel && penable && pready && pwrite;
  wire        conv_hit  = !paddr[7];
  wire        conv_n    = paddr[`CONV_BLOCK_BIT];
  wire [5:0]  conv_off  = paddr[5:0];
  wire        res_hit   = conv_hit && conv_off >= `OFF_RES0 && conv_off <= `OFF_RES3;
  wire [2:0]  res_sel   = {conv_n, conv_off[3:2]};
  wire        aligned   = (paddr[1:0] == 2'b00);
  wire        ctl_hit   = conv_hit && (conv_off == `OFF_MODE || conv_off == `OFF_CLK ||
                                       conv_off == `OFF_TRIG || conv_off == `OFF_CHAN);
  wire        glb_hit   = paddr == `OFF_TOPT_A || paddr == `OFF_TOPT_B ||
                          paddr == `OFF_IRQ_STS || paddr == `OFF_IRQ_MSK;
  wire        mapped    = aligned && (ctl_hit || res_hit || glb_hit);
  wire        wr_mode   = xfer_wr && conv_hit && conv_off == `OFF_MODE;
  wire        wr_trig   = xfer_wr && conv_hit && conv_off == `OFF_TRIG;
  wire        wr_chan   = xfer_wr && conv_hit && conv_off == `OFF_CHAN;
  wire        wr_clk    = xfer_wr && conv_hit && conv_off == `OFF_CLK;
  wire        wr_sts    = xfer_wr && paddr == `OFF_IRQ_STS;

  // read data selection
  wire [7:0]  mode_rd   = {conv_mode_reg_r[conv_n][7], seq_active[conv_n],
                           conv_mode_reg_r[conv_n][5:0]};
  wire [31:0] rd_data   =
    !mapped                            ? 32'h0000_0000 :
    (res_hit)                          ? {{(32-RES_W){1'b0}}, result_reg_r[res_sel]} :
    (conv_hit && conv_off == `OFF_MODE) ? {24'h00_0000, mode_rd} :
    (conv_hit && conv_off == `OFF_CLK)  ? {30'h0, conv_clock_reg_r[conv_n]} :
    (conv_hit && conv_off == `OFF_TRIG) ? {30'h0, conv_trigger_mode_reg_r[conv_n]} :
    (conv_hit && conv_off == `OFF_CHAN) ? {30'h0, channel_select_reg_r[conv_n]} :
    (paddr == `OFF_TOPT_A)             ? {28'h0, timer_option_reg_a_r} :
    (paddr == `OFF_TOPT_B)             ? {28'h0, timer_option_reg_b_r} :
    (paddr == `OFF_IRQ_STS)            ? {30'h0, irq_sts_r} :
                                         {30'h0, irq_msk_r};

  // sticky status: conversion end sets, write-one clears, set wins
  assign irq_sts_nxt = (irq_sts_r & ~(wr_sts ? pwdata[1:0] : 2'b00)) | seq_done;

  // timer trigger level and edge per converter
  wire [3:0]  tmr_events = {timer_q_overflow_event, timer_q_compare0_event,
                            timer_p_compare1_event, timer_p_compare0_event};
  wire [1:0]  tmr_level  = {timer_trig(timer_option_reg_b_r, tmr_events),
                            timer_trig(timer_option_reg_a_r, tmr_events)};
  wire [1:0]  start_nxt;

  // source select: timer rising edge or qualified pin edge
  for (genvar n = 0; n < 2; n++)
  begin : g_trig
    wire use_tmr = conv_trigger_mode_reg_r[n][`TRIG_SRC_BIT];
    wire tmr_hit = tmr_level[n] && !tmr_prev_r[n];
    wire ext_hit = edge_hit(conv_mode_reg_r[n][`MODE_ETS_LSB +: 2], ext_sync_r[n],
                            ext_prev_r[n]);
    assign start_nxt[n] = use_tmr ? tmr_hit : ext_hit;
  end

  // apb handshake: no wait state, registered answer
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
    end
  end

  // trigger synchronisers and edge history
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_meta_r <= 2'b00;
      ext_sync_r <= 2'b00;
      ext_prev_r <= 2'b00;
      tmr_prev_r <= 2'b00;
      start_r    <= 2'b00;
    end
    else
    begin
      ext_meta_r <= {ext_trigger_pin1, ext_trigger_pin0};
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      tmr_prev_r <= tmr_level;
      start_r    <= start_nxt;
    end
  end

  // control registers, written only in a completed access phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        conv_mode_reg_r[i]         <= `MODE_RST;
        conv_clock_reg_r[i]        <= `CLK_RST;
        conv_trigger_mode_reg_r[i] <= `TRIG_RST;
        channel_select_reg_r[i]    <= `CHAN_RST;
      end
      timer_option_reg_a_r <= `TOPT_RST;
      timer_option_reg_b_r <= `TOPT_RST;
      irq_msk_r            <= `IRQ_RST;
      stop_req_r           <= 2'b00;
    end
    else
    begin
      // the enable bit changes only by software writes
      if (wr_mode)
        conv_mode_reg_r[conv_n] <= pwdata[7:0];
      if (wr_clk)
        conv_clock_reg_r[conv_n] <= pwdata[1:0];
      if (wr_trig)
        conv_trigger_mode_reg_r[conv_n] <= pwdata[1:0];
      if (wr_chan)
        channel_select_reg_r[conv_n] <= pwdata[1:0];
      if (xfer_wr && paddr == `OFF_TOPT_A)
        timer_option_reg_a_r <= pwdata[3:0];
      if (xfer_wr && paddr == `OFF_TOPT_B)
        timer_option_reg_b_r <= pwdata[3:0];
      if (xfer_wr && paddr == `OFF_IRQ_MSK)
        irq_msk_r <= pwdata[1:0];
      stop_req_r[0] <= (wr_mode || wr_trig || wr_chan) && !conv_n;
      stop_req_r[1] <= (wr_mode || wr_trig || wr_chan) && conv_n;
    end
  end

  // result storage and interrupt
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        result_reg_r[i] <= '0;
      irq_sts_r          <= `IRQ_RST;
      conversion_end_irq <= 1'b0;
    end
    else
    begin
      for (int n = 0; n < 2; n++)
        if (seq_store_we[n])
          result_reg_r[{n[0], seq_store_idx[n]}] <= seq_store_data[n];
      irq_sts_r          <= irq_sts_nxt;
      conversion_end_irq <= |(irq_sts_nxt & irq_msk_r);
    end
  end

  // one independent sequencer per converter
  for (genvar n = 0; n < 2; n++)
  begin : g_conv
    conv_sequencer #(
      .RES_W (RES_W)
    ) u_seq (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .enable      (conv_mode_reg_r[n][`MODE_EN_BIT]),
      .start       (start_r[n]),
      .stop_req    (stop_req_r[n]),
      .buf4        (conv_trigger_mode_reg_r[n][`TRIG_BUF4_BIT]),
      .scan        (conv_mode_reg_r[n][`MODE_OPM_LSB]),
      .chan_sel    (channel_select_reg_r[n]),
      .conv_cycles (conv_len(conv_clock_reg_r[n])),
      .sample_data ((n == 0) ? sample_data0 : sample_data1),
      .active      (seq_active[n]),
      .store_we    (seq_store_we[n]),
      .store_idx   (seq_store_idx[n]),
      .store_data  (seq_store_data[n]),
      .done        (seq_done[n]),
      .chan        (seq_chan[n])
    );
  end

  // analog channel outputs, each registered inside its sequencer
  assign analog_input_channel0 = seq_chan[0];
  assign analog_input_channel1 = seq_chan[1];
endmodule : adc_trig_top
`default_nettype wire

// File: tb/adc_trig_top_props.sv
// bus and interrupt assertions bound to the sequencer top
`default_nettype none
module adc_trig_top_props #(
  parameter int RES_W = 10
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // apb and interrupt
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conversion_end_irq
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // completed transfer
  wire logic xfer = psel && penable && pready;
  // access phase is exactly one cycle
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready in the access phase");
  AST_READY_ONCE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_READY_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  // refused and accepted places
  AST_UNALIGNED: assert property (xfer && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access accepted");
  AST_UNMAPPED: assert property (xfer && paddr >= 8'h90 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  AST_MAPPED_OK: assert property (xfer && paddr[5:0] < 6'h20 && paddr[1:0] == 2'h0
    && paddr < 8'h80 |-> !pslverr)
    else $error("mapped access refused");
  AST_UPPER_ZERO: assert property (xfer && !pwrite |-> prdata[31:RES_W] == '0)
    else $error("upper read bits not zero");
  // masking everything drops the line two edges later
  AST_MASK_OFF: assert property (xfer && pwrite && paddr == 8'h8c
    && pwdata[1:0] == 2'h0 |-> ##2 !conversion_end_irq)
    else $error("interrupt stays up with all masked");
endmodule : adc_trig_top_props
bind adc_trig_top adc_trig_top_props #(.RES_W(RES_W)) u_adc_trig_top_props (
  .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
  .pslverr, .conversion_end_irq
);
`default_nettype wire

// File: tb/trig_src_model.sv
// model of the motor-control timer events and external trigger pins
`default_nettype none
module trig_src_model (
  // clock
  input  wire logic       sys_clk,
  // timer events and pins
  output logic [3:0]      tmr_ev,
  output logic [1:0]      ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    tmr_ev = 4'h0;
    ext_pin = 2'h0;
  end
  // raise one timer event for a number of cycles
  task automatic fire(input int idx, input int width);
    @(posedge sys_clk);
    tmr_ev[idx] <= 1'b1;
    repeat (width) @(posedge sys_clk);
    tmr_ev[idx] <= 1'b0;
  endtask : fire
  // move one trigger pin to a new level
  task automatic set_pin(input int idx, input logic lvl);
    @(posedge sys_clk);
    ext_pin[idx] <= lvl;
  endtask : set_pin
endmodule : trig_src_model
`default_nettype wire

// File: tb/adc_hardware_trigger_sequencer_tb.sv
// self-checking bench of the two-converter trigger sequencer
`default_nettype none
module adc_hardware_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  tmr_ev;
  logic [1:0]  ext_pin;
  logic [9:0]  sd0 = 10'h0;
  logic [9:0]  sd1 = 10'h0;
  logic [1:0]  ch0;
  logic [1:0]  ch1;
  logic        irq;
  logic [9:0]  base0 = 10'h0;
  logic [9:0]  base1 = 10'h0;
  logic [9:0]  keep;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  logic [7:0]  ra[4] = '{8'h0c, 8'h08, 8'h00, 8'h00};
  logic [31:0] rv[4] = '{32'h1, 32'h2, 32'h80, 32'h0};
  int          num_errors = 0;
  int          num_checks = 0;
  int          n;
  integer      seed = 32'h8ca0;
  adc_trig_top #(.RES_W(10)) u_adc_trig_top (
    .sys_clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .timer_p_compare0_event(tmr_ev[0]), .timer_p_compare1_event(tmr_ev[1]),
    .timer_q_compare0_event(tmr_ev[2]), .timer_q_overflow_event(tmr_ev[3]),
    .ext_trigger_pin0(ext_pin[0]), .ext_trigger_pin1(ext_pin[1]),
    .sample_data0(sd0), .sample_data1(sd1), .analog_input_channel0(ch0),
    .analog_input_channel1(ch1), .conversion_end_irq(irq)
  );
  trig_src_model u_trig_src_model (.sys_clk, .tmr_ev, .ext_pin);
  always #4 sys_clk = ~sys_clk;
  // converter data marks the channel it was taken from
  always @(posedge sys_clk)
  begin
    sd0 <= base0 ^ {8'h0, ch0};
    sd1 <= base1 ^ {8'h0, ch1};
  end
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, held until ready is sampled
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff, input logic er = 1'b0);
    exp_q.push_back({er, e & m});
    msk_q.push_back({1'b1, m});
    apb(a, 1'b0, 32'h0);
  endtask : rd
  // interrupt must come after lo and before hi cycles
  task automatic wait_irq(input int lo, input int hi);
    n = 0;
    while (irq !== 1'b1 && n < hi)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk(33'(n > lo && n < hi), 33'h1);
  endtask : wait_irq
  task automatic end_of_test;
    if (exp_q.size() != 0)
      num_errors++;
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // compare each completed read with the oldest note
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata} & msk_q.pop_front(), exp_q.pop_front());
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    // reset values, read-only flag, refused places
    rd(8'h04, 32'h1);
    rd(8'h48, 32'h0);
    rd(8'h84, 32'h0);
    rd(8'h88, 32'h0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    rd(8'h02, 32'h0, 32'hffffffff, 1'b1);
    wr(8'h00, 32'h40);
    rd(8'h00, 32'h0);
    wr(8'h8c, 32'h3);
    // converter 1 on other events, converter 0 timer select, one-shot field set
    wr(8'h48, 32'h2);
    wr(8'h40, 32'h80);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'ha0);
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h80, 32'h1 << i);
      wr(8'h84, 32'h8 >> i);
      base0 = 10'($random(seed));
      u_trig_src_model.fire(i, 12);
      rd(8'h00, 32'hc0, 32'hc0);
      wait_irq(40, 200);
      rd(8'h14, {22'h0, base0 ^ 10'h1});
      rd(8'h88, 32'h1);
      rd(8'h00, 32'ha0, 32'he0);
      wr(8'h88, 32'h1);
    end
    // a held event starts converter 1 once
    base1 = 10'($random(seed));
    u_trig_src_model.fire(0, 150);
    rd(8'h88, 32'h2);
    rd(8'h50, {22'h0, base1});
    wr(8'h88, 32'h2);
    repeat (100) @(posedge sys_clk);
    rd(8'h88, 32'h0);
    // rising pin edge, four results on converter 1
    wr(8'h4c, 32'h2);
    wr(8'h48, 32'h1);
    wr(8'h40, 32'h84);
    base1 = 10'($random(seed));
    u_trig_src_model.set_pin(1, 1'b1);
    wait_irq(240, 400);
    for (int k = 0; k < 4; k++)
      rd(8'h50 + 8'(4 * k), {22'h0, base1 ^ 10'h2});
    wr(8'h88, 32'h2);
    // every edge choice, falling then rising
    wr(8'h48, 32'h0);
    for (int es = 0; es < 4; es++)
    begin
      wr(8'h40, 32'h80 | 32'(es << 2));
      for (int lv = 0; lv < 2; lv++)
      begin
        u_trig_src_model.set_pin(1, lv[0]);
        repeat (90) @(posedge sys_clk);
        rd(8'h88, {30'h0, lv[0] ? es[0] : es[1], 1'b0});
        wr(8'h88, 32'h2);
      end
    end
    // scan of channels 0 to 3 on converter 0
    wr(8'h80, 32'h1);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h90);
    base0 = 10'($random(seed));
    u_trig_src_model.fire(0, 4);
    wait_irq(180, 400);
    for (int c = 0; c < 4; c++)
      rd(8'h10 + 8'(4 * c), {22'h0, base0 ^ 10'(c)});
    wr(8'h88, 32'h1);
    // retrigger mid-conversion, closer than a conversion
    wr(8'h0c, 32'h1);
    wr(8'h00, 32'h80);
    u_trig_src_model.fire(0, 4);
    repeat (20) @(posedge sys_clk);
    base0 = 10'($random(seed));
    keep = base0 ^ 10'h1;
    u_trig_src_model.fire(0, 4);
    repeat (40) @(posedge sys_clk);
    rd(8'h88, 32'h0);
    wait_irq(15, 30);
    rd(8'h14, {22'h0, keep});
    wr(8'h88, 32'h1);
    // register writes and disabling stop a conversion unstored
    base0 = ~base0;
    for (int r = 0; r < 4; r++)
    begin
      u_trig_src_model.fire(0, 4);
      repeat (10) @(posedge sys_clk);
      wr(ra[r], rv[r]);
      repeat (90) @(posedge sys_clk);
      rd(8'h88, 32'h0);
      rd(8'h14, {22'h0, keep});
    end
    // masked end sets status but keeps the line low
    wr(8'h8c, 32'h2);
    wr(8'h00, 32'h80);
    u_trig_src_model.fire(0, 4);
    repeat (90) @(posedge sys_clk);
    chk({32'h0, irq}, 33'h0);
    rd(8'h88, 32'h1);
    wr(8'h8c, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk({32'h0, irq}, 33'h1);
    wr(8'h88, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk({32'h0, irq}, 33'h0);
    // slowest clock setting, then masking drops a raised line
    wr(8'h04, 32'h3);
    u_trig_src_model.fire(0, 4);
    wait_irq(110, 140);
    wr(8'h8c, 32'h0);
    repeat (3) @(posedge sys_clk);
    chk({32'h0, irq}, 33'h0);
    end_of_test;
  end
endmodule : adc_hardware_trigger_sequencer_tb
`default_nettype wire
